/* ubrb_defines.svh */
// ubrb_defines.svh: field values and timing counts of the serial port
// assumes: included by bare name from the design modules
`ifndef UBRB_DEFINES_SVH
`define UBRB_DEFINES_SVH
// ==========================================================
// timing
`define UBRB_CLK_NS 4
// bit rate = setting / 0.004096 s, so 0.004096 s written in ns
`define UBRB_RATE_CONST_NS 4096000
`define UBRB_OVS 16
// one unit of the break timeout setting
`define UBRB_BRK_UNIT_NS 1000000
// host end fixed rate
`define UBRB_HOST_BPS 115200
`define UBRB_CLK_HZ 250000000
// ==========================================================
// field values
`define UBRB_DATA_BITS 8
`define UBRB_RATE_RST 16'h01D8
`define UBRB_FIFO_DEPTH 32
`endif

/* ubrb_pkg.sv */
// ubrb_pkg.sv: types shared by both ends of the serial link
// assumes: ubrb_defines.svh holds the numbers
package ubrb_pkg;
  // ==========================================================
  // parity modes
  typedef enum logic [1:0] {
    UBRB_PAR_NONE = 2'h0,
    UBRB_PAR_ODD = 2'h1,
    UBRB_PAR_EVEN = 2'h2
  } ubrb_par_t;
  // ==========================================================
  // frame states
  typedef enum logic [2:0] {
    UBRB_IDLE = 3'h0,
    UBRB_START = 3'h1,
    UBRB_DATA = 3'h2,
    UBRB_PAR = 3'h3,
    UBRB_STOP = 3'h4,
    UBRB_BRK = 3'h5
  } ubrb_st_t;
endpackage

/* ubrb_if.sv */
// ubrb_if.sv: the serial wires between host and device
// assumes: each end drives its outputs with enables; levels resolved here
`timescale 1ns/100ps
interface ubrb_if;
  logic h2d, h2d_oe, h_rts_n, h_rts_oe;
  logic d2h, d2h_oe, d_rts_n, d_rts_oe;
  logic bypass_req;
  logic h2d_line, h_rts_line, d2h_line, d_rts_line;
  // ==========================================================
  // undriven data lines idle high, undriven handshake reads asserted
  assign h2d_line = h2d_oe ? h2d : 1'b1;
  assign d2h_line = d2h_oe ? d2h : 1'b1;
  assign h_rts_line = h_rts_oe ? h_rts_n : 1'b0;
  assign d_rts_line = d_rts_oe ? d_rts_n : 1'b0;
  modport dev (
    output d2h, d2h_oe, d_rts_n, d_rts_oe,
    input h2d_line, h_rts_line, bypass_req
  );
  modport host (
    output h2d, h2d_oe, h_rts_n, h_rts_oe, bypass_req,
    input d2h_line, d_rts_line
  );
endinterface

/* ubrb_fifo.sv */
// ubrb_fifo.sv: receive buffer with valid/ready on both sides
// assumes: one clock; depth is a power of two
`timescale 1ns/100ps
`include "ubrb_defines.svh"
module ubrb_fifo #(
  parameter int W = 9,
  parameter int DEPTH = `UBRB_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic push, pop;
  assign o_in_ready = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign o_out_valid = wp_r != rp_r;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rp_r[AW-1:0]];
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= i_in_data;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

/* ubrb_dev_end.sv */
// ubrb_dev_end.sv: device end of the serial port with break reset and bypass
// assumes: link pins synchronous to i_clk; the host keeps its own obligations
// Function
// - one receive and one transmit async line
// - flow control is handshake or none
// - both handshake lines are active low
// - eight data bits, parity choice, one/two stops
// - any bit rate from 1200 to 3M
// - bit rate is setting over 0.004096
// - standard settings give the standard rates
// - break is receive line held low
// - break longer than timeout resets the module; the code clears only the tick, transmitter and receiver, not the receive FIFO
// - transmitter can send a break to wake
// - outputs float while reset is held
// - other drivers release bus after reset ends
// - after reset host reaches internal port
// - bypass command routes host to bypass pins
// - bypass means deep sleep, routing kept
// - only a reset leaves bypass mode
// - host closes radio links before bypass
`timescale 1ns/100ps
`include "ubrb_defines.svh"
module ubrb_dev_end #(
  parameter int BRK_UNIT_CYC = `UBRB_BRK_UNIT_NS / `UBRB_CLK_NS,
  parameter int FIFO_DEPTH = `UBRB_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link
  ubrb_if.dev lnk,
  // configuration
  input wire logic [15:0] i_bit_rate_setting,
  input wire logic [15:0] i_break_reset_timeout_setting,
  input wire logic i_flow_en,
  input ubrb_pkg::ubrb_par_t i_parity,
  input wire logic i_two_stop,
  // transmit
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic i_send_break,
  // receive
  output logic [7:0] o_rx_data,
  output logic o_rx_err,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic o_rx_overrun,
  // system
  output logic o_break_reset,
  output logic o_deep_sleep,
  // bypass pins
  output logic [3:0] o_bypass_pins_out,
  output logic [3:0] o_bypass_pins_oe,
  input wire logic [3:0] i_bypass_pins_in
);
  import ubrb_pkg::*;
  localparam logic [16:0] ACC_MOD = 17'(`UBRB_RATE_CONST_NS / `UBRB_CLK_NS / `UBRB_OVS);
  localparam logic [31:0] BRK_LAST = 32'(BRK_UNIT_CYC - 1);
  localparam logic [2:0] LAST_BIT = 3'(`UBRB_DATA_BITS - 1);
  logic [16:0] acc_r, acc_sum;
  logic tick;
  logic srst_r, bypass_r, oe_r;
  logic [31:0] pre_r;
  logic [15:0] units_r;
  logic fired_r;
  ubrb_st_t tx_st_r, rx_st_r;
  logic [3:0] tx_sub_r, rx_sub_r;
  logic [2:0] tx_cnt_r, rx_cnt_r;
  logic [7:0] tx_sh_r, rx_sh_r;
  logic tx_par_r, tx_line_r, rx_perr_r, push_r, rts_n_r;
  logic [8:0] push_data_r, out_data;
  logic fifo_in_ready, tx_bit_done, rx_mid, cts_ok, rx_line;

  // ==========================================================
  // oversample tick: rate = setting * 250 MHz / 1024000 per 16 ticks
  assign acc_sum = acc_r + {1'b0, i_bit_rate_setting};
  assign tick = acc_sum >= ACC_MOD;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_r <= '0;
    end else if (srst_r) begin
      acc_r <= '0;
    end else if (tick) begin
      acc_r <= acc_sum - ACC_MOD;
    end else begin
      acc_r <= acc_sum;
    end
  end

  // ==========================================================
  // break detection and self reset
  assign rx_line = lnk.h2d_line;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pre_r <= '0;
      units_r <= '0;
      fired_r <= 1'b0;
      srst_r <= 1'b0;
    end else begin
      srst_r <= 1'b0;
      if (rx_line || bypass_r) begin
        pre_r <= '0;
        units_r <= '0;
        fired_r <= 1'b0;
      end else if (units_r > i_break_reset_timeout_setting) begin
        srst_r <= !fired_r;
        fired_r <= 1'b1;
      end else if (pre_r == BRK_LAST) begin
        pre_r <= '0;
        units_r <= units_r + 16'h0001;
      end else begin
        pre_r <= pre_r + 32'h00000001;
      end
    end
  end
  assign o_break_reset = srst_r;

  // ==========================================================
  // bypass latch and pin enable
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bypass_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      oe_r <= 1'b1;
      if (lnk.bypass_req) begin
        bypass_r <= 1'b1;
      end
    end
  end
  assign o_deep_sleep = bypass_r;

  // ==========================================================
  // transmitter
  assign cts_ok = !i_flow_en || !lnk.h_rts_line;
  assign tx_bit_done = tick && (tx_sub_r == 4'hF);
  assign o_tx_ready = (tx_st_r == UBRB_IDLE) && !i_send_break && cts_ok && !bypass_r;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_st_r <= UBRB_IDLE;
      tx_sub_r <= '0;
      tx_cnt_r <= '0;
      tx_sh_r <= '0;
      tx_par_r <= 1'b0;
      tx_line_r <= 1'b1;
    end else if (srst_r || bypass_r) begin
      tx_st_r <= UBRB_IDLE;
      tx_sub_r <= '0;
      tx_line_r <= 1'b1;
    end else begin
      if (tick) begin
        tx_sub_r <= tx_sub_r + 4'h1;
      end
      case (tx_st_r)
        UBRB_IDLE: begin
          tx_sub_r <= '0;
          if (i_send_break) begin
            tx_st_r <= UBRB_BRK;
            tx_line_r <= 1'b0;
          end else if (i_tx_valid && cts_ok) begin
            tx_st_r <= UBRB_START;
            tx_sh_r <= i_tx_data;
            tx_par_r <= (i_parity == UBRB_PAR_ODD) ? ~^i_tx_data : ^i_tx_data;
            tx_line_r <= 1'b0;
          end
        end
        UBRB_START: begin
          if (tx_bit_done) begin
            tx_st_r <= UBRB_DATA;
            tx_cnt_r <= '0;
            tx_line_r <= tx_sh_r[0];
          end
        end
        UBRB_DATA: begin
          if (tx_bit_done) begin
            if (tx_cnt_r == LAST_BIT) begin
              tx_cnt_r <= '0;
              tx_st_r <= (i_parity == UBRB_PAR_NONE) ? UBRB_STOP : UBRB_PAR;
              tx_line_r <= (i_parity == UBRB_PAR_NONE) ? 1'b1 : tx_par_r;
            end else begin
              tx_cnt_r <= tx_cnt_r + 3'h1;
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
              tx_line_r <= tx_sh_r[1];
            end
          end
        end
        UBRB_PAR: begin
          if (tx_bit_done) begin
            tx_st_r <= UBRB_STOP;
            tx_line_r <= 1'b1;
          end
        end
        UBRB_STOP: begin
          if (tx_bit_done) begin
            if (i_two_stop && (tx_cnt_r == 3'h0)) begin
              tx_cnt_r <= 3'h1;
            end else begin
              tx_st_r <= UBRB_IDLE;
            end
          end
        end
        UBRB_BRK: begin
          if (!i_send_break) begin
            tx_st_r <= UBRB_STOP;
            tx_cnt_r <= 3'h1;
            tx_sub_r <= '0;
            tx_line_r <= 1'b1;
          end
        end
        default: tx_st_r <= UBRB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // receiver, sampling at bit centres
  assign rx_mid = tick && (rx_sub_r == 4'hF);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_st_r <= UBRB_IDLE;
      rx_sub_r <= '0;
      rx_cnt_r <= '0;
      rx_sh_r <= '0;
      rx_perr_r <= 1'b0;
      push_r <= 1'b0;
      push_data_r <= '0;
    end else if (srst_r || bypass_r) begin
      rx_st_r <= UBRB_IDLE;
      push_r <= 1'b0;
    end else begin
      push_r <= 1'b0;
      if (tick) begin
        rx_sub_r <= rx_sub_r + 4'h1;
      end
      case (rx_st_r)
        UBRB_IDLE: begin
          rx_sub_r <= '0;
          rx_perr_r <= 1'b0;
          if (!rx_line) begin
            rx_st_r <= UBRB_START;
          end
        end
        UBRB_START: begin
          if (tick && (rx_sub_r == 4'h7)) begin
            rx_sub_r <= '0;
            rx_cnt_r <= '0;
            rx_st_r <= rx_line ? UBRB_IDLE : UBRB_DATA;
          end
        end
        UBRB_DATA: begin
          if (rx_mid) begin
            rx_sh_r <= {rx_line, rx_sh_r[7:1]};
            if (rx_cnt_r == LAST_BIT) begin
              rx_st_r <= (i_parity == UBRB_PAR_NONE) ? UBRB_STOP : UBRB_PAR;
            end else begin
              rx_cnt_r <= rx_cnt_r + 3'h1;
            end
          end
        end
        UBRB_PAR: begin
          if (rx_mid) begin
            rx_perr_r <= rx_line != ((i_parity == UBRB_PAR_ODD) ? ~^rx_sh_r : ^rx_sh_r);
            rx_st_r <= UBRB_STOP;
          end
        end
        UBRB_STOP: begin
          if (rx_mid) begin
            push_r <= 1'b1;
            push_data_r <= {rx_perr_r || !rx_line, rx_sh_r};
            rx_st_r <= UBRB_IDLE;
          end
        end
        default: rx_st_r <= UBRB_IDLE;
      endcase
    end
  end

  ubrb_fifo #(.W(9), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_in_valid(push_r),
    .o_in_ready(fifo_in_ready),
    .i_in_data(push_data_r),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(out_data)
  );
  assign o_rx_data = out_data[7:0];
  assign o_rx_err = out_data[8];
  assign o_rx_overrun = push_r && !fifo_in_ready;

  // ==========================================================
  // handshake output and pin routing
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rts_n_r <= 1'b1;
    end else begin
      rts_n_r <= i_flow_en && !fifo_in_ready;
    end
  end
  assign lnk.d2h = bypass_r ? i_bypass_pins_in[2] : tx_line_r;
  assign lnk.d_rts_n = bypass_r ? i_bypass_pins_in[3] : rts_n_r;
  assign lnk.d2h_oe = oe_r;
  assign lnk.d_rts_oe = oe_r;
  assign o_bypass_pins_out = {2'b00, lnk.h_rts_line, rx_line};
  assign o_bypass_pins_oe = bypass_r ? 4'h3 : 4'h0;
endmodule

/* ubrb_host_end.sv */
// ubrb_host_end.sv: host end of the serial link, fixed 8N1 at a set rate
// assumes: the device runs the same rate; pins synchronous to i_clk
`timescale 1ns/100ps
`include "ubrb_defines.svh"
module ubrb_host_end #(
  parameter int CLKS_PER_BIT = `UBRB_CLK_HZ / `UBRB_HOST_BPS
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link
  ubrb_if.host lnk,
  // control
  input wire logic i_drive_en,
  input wire logic i_flow_en,
  input wire logic i_send_break,
  input wire logic i_bypass_cmd,
  input wire logic i_links_closed,
  // transmit
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  // receive
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready
);
  import ubrb_pkg::*;
  localparam logic [15:0] CPB_LAST = 16'(CLKS_PER_BIT - 1);
  localparam logic [15:0] CPB_HALF = 16'(CLKS_PER_BIT / 2);
  logic [15:0] tc_r, rc_r;
  logic [3:0] tn_r, rn_r;
  logic [9:0] tsh_r;
  logic [7:0] rsh_r;
  logic tbusy_r, rbusy_r, line_r, byp_r;
  // ==========================================================
  // transmitter: start, 8 data lsb first, stop
  assign o_tx_ready = !tbusy_r && !i_send_break && (!i_flow_en || !lnk.d_rts_line);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tbusy_r <= 1'b0;
      tc_r <= '0;
      tn_r <= '0;
      tsh_r <= '1;
      line_r <= 1'b1;
    end else if (!tbusy_r) begin
      line_r <= !i_send_break;
      if (o_tx_ready && i_tx_valid) begin
        tbusy_r <= 1'b1;
        tsh_r <= {1'b1, i_tx_data, 1'b0};
        line_r <= 1'b0;
        tc_r <= '0;
        tn_r <= '0;
      end
    end else if (tc_r == CPB_LAST) begin
      tc_r <= '0;
      if (tn_r == 4'h9) begin
        tbusy_r <= 1'b0;
        line_r <= 1'b1;
      end else begin
        tn_r <= tn_r + 4'h1;
        tsh_r <= {1'b1, tsh_r[9:1]};
        line_r <= tsh_r[1];
      end
    end else begin
      tc_r <= tc_r + 16'h0001;
    end
  end
  assign lnk.h2d = line_r;
  assign lnk.h2d_oe = i_drive_en;
  assign lnk.h_rts_oe = i_drive_en;
  assign lnk.h_rts_n = i_flow_en && o_rx_valid;
  // ==========================================================
  // receiver with single holding register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rbusy_r <= 1'b0;
      rc_r <= '0;
      rn_r <= '0;
      rsh_r <= '0;
      o_rx_data <= '0;
      o_rx_valid <= 1'b0;
    end else begin
      if (o_rx_valid && i_rx_ready) begin
        o_rx_valid <= 1'b0;
      end
      if (!rbusy_r) begin
        rc_r <= '0;
        rn_r <= '0;
        rbusy_r <= !lnk.d2h_line;
      end else if ((rn_r == 4'h0) ? (rc_r == CPB_HALF) : (rc_r == CPB_LAST)) begin
        rc_r <= '0;
        rn_r <= rn_r + 4'h1;
        if (rn_r == 4'h0 && lnk.d2h_line) begin
          rbusy_r <= 1'b0;
        end else if (rn_r == 4'h9) begin
          rbusy_r <= 1'b0;
          o_rx_data <= rsh_r;
          o_rx_valid <= 1'b1;
        end else if (rn_r != 4'h0) begin
          rsh_r <= {lnk.d2h_line, rsh_r[7:1]};
        end
      end else begin
        rc_r <= rc_r + 16'h0001;
      end
    end
  end
  // ==========================================================
  // bypass request only with radio links closed
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      byp_r <= 1'b0;
    end else begin
      byp_r <= i_bypass_cmd && i_links_closed;
    end
  end
  assign lnk.bypass_req = byp_r;
endmodule

/* ubrb_link_assertions.sv */
// ubrb_link_assertions.sv: checks on the serial wires between host and device ends
// assumes: instantiated in tb beside the link interface; one clock domain
`timescale 1ns/100ps
module ubrb_link_assertions (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // link signals
  input wire logic d2h_oe,
  input wire logic d_rts_oe,
  input wire logic bypass_req,
  input wire logic h2d_line,
  input wire logic d2h_line,
  input wire logic d_rts_line
);
  logic byp_r, dp_r, hp_r;
  logic [7:0] dcnt_r, hcnt_r;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ==========================================================
  // helpers: bypass seen, cycles since each start bit
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      byp_r <= 1'b0;
    end else if (bypass_req) begin
      byp_r <= 1'b1;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dp_r <= 1'b1;
      hp_r <= 1'b1;
    end else begin
      dp_r <= d2h_line;
      hp_r <= h2d_line;
    end
  end
  // a fall past the last data bit can only be a new start
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dcnt_r <= 8'hFF;
    end else if (dp_r && !d2h_line && dcnt_r >= 8'h91) begin
      dcnt_r <= 8'h01;
    end else if (dcnt_r < 8'hFF) begin
      dcnt_r <= dcnt_r + 8'h01;
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      hcnt_r <= 8'hFF;
    end else if (hp_r && !h2d_line && hcnt_r >= 8'h91) begin
      hcnt_r <= 8'h01;
    end else if (hcnt_r < 8'hFF) begin
      hcnt_r <= hcnt_r + 8'h01;
    end
  end
  // ==========================================================
  // assertions
  a_float_in_reset:
    assert property (disable iff (1'b0) i_rst |-> !d2h_oe && !d_rts_oe)
    else $error("device drove the link during reset");
  a_drive_after_reset:
    assert property ($fell(i_rst) |=> d2h_oe && d_rts_oe)
    else $error("device did not drive the link after reset");
  a_drive_kept:
    assert property (d2h_oe |=> d2h_oe)
    else $error("device released the link without reset");
  a_dev_start_len:
    assert property ($fell(d2h_line) && !byp_r |-> !d2h_line [*8])
    else $error("device start bit too short");
  a_host_start_len:
    assert property ($fell(h2d_line) |-> !h2d_line [*8])
    else $error("host start bit too short");
  a_bypass_pulse:
    assert property (bypass_req |=> !bypass_req)
    else $error("bypass request longer than one cycle");
  a_dev_bit_grid:
    assert property ((d2h_line != dp_r) && dcnt_r < 8'h91 && !byp_r |-> dcnt_r[3:0] == 4'h0)
    else $error("device bit edge off the bit grid");
  a_host_bit_grid:
    assert property ((h2d_line != hp_r) && hcnt_r < 8'h91 |-> hcnt_r[3:0] == 4'h0)
    else $error("host bit edge off the bit grid");
  c_bypass: cover property (bypass_req);
  c_dev_frame: cover property ($fell(d2h_line) && !byp_r);
  c_rts_full: cover property ($rose(d_rts_line));
endmodule

/* ubrb_tb.sv */
// ubrb_tb.sv: host end and device end joined by the link, scenario tasks
// assumes: both ends at 16 clocks per bit; break unit shortened to 4 clocks
`timescale 1ns/100ps
module tb;
  import ubrb_pkg::*;
  logic clk, rst, d_flow, d_two, d_tv, d_brk, d_rr, h_drv, h_flow, h_brk, h_byp, h_lc;
  logic h_tv, h_rr, d_tr, d_err, d_rv, d_ovr, d_bres, d_sleep, h_tr, h_rv;
  logic [15:0] brk_to;
  logic [7:0] d_td, h_td, d_rd, h_rd;
  logic [3:0] pin_in, pin_out, pin_oe;
  ubrb_par_t d_par;
  int n_fail, samples_checked, n_ovr;
  ubrb_if lnk();
  ubrb_dev_end #(.BRK_UNIT_CYC(4), .FIFO_DEPTH(32)) ubrb_dev_end_i (.i_clk(clk), .i_rst(rst),
    .lnk(lnk.dev), .i_bit_rate_setting(16'hFA00), .i_break_reset_timeout_setting(brk_to),
    .i_flow_en(d_flow), .i_parity(d_par), .i_two_stop(d_two), .i_tx_data(d_td),
    .i_tx_valid(d_tv), .o_tx_ready(d_tr), .i_send_break(d_brk), .o_rx_data(d_rd),
    .o_rx_err(d_err), .o_rx_valid(d_rv), .i_rx_ready(d_rr), .o_rx_overrun(d_ovr),
    .o_break_reset(d_bres), .o_deep_sleep(d_sleep), .o_bypass_pins_out(pin_out),
    .o_bypass_pins_oe(pin_oe), .i_bypass_pins_in(pin_in));
  ubrb_host_end #(.CLKS_PER_BIT(16)) ubrb_host_end_i (.i_clk(clk), .i_rst(rst),
    .lnk(lnk.host), .i_drive_en(h_drv), .i_flow_en(h_flow), .i_send_break(h_brk),
    .i_bypass_cmd(h_byp), .i_links_closed(h_lc), .i_tx_data(h_td), .i_tx_valid(h_tv),
    .o_tx_ready(h_tr), .o_rx_data(h_rd), .o_rx_valid(h_rv), .i_rx_ready(h_rr));
  ubrb_link_assertions ubrb_link_assertions_i (.i_clk(clk), .i_rst(rst),
    .d2h_oe(lnk.d2h_oe), .d_rts_oe(lnk.d_rts_oe), .bypass_req(lnk.bypass_req),
    .h2d_line(lnk.h2d_line), .d2h_line(lnk.d2h_line), .d_rts_line(lnk.d_rts_line));
  // ==========================================================
  // common tasks
  always @(posedge clk) if (d_ovr === 1'b1) n_ovr <= n_ovr + 1;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic host_send(input logic [7:0] b);
    h_td = b;
    h_tv = 1'b1;
    for (int i = 0; i < 4000 && h_tr !== 1'b1; i++) cyc(1);
    chk("host_tx_ready", 16'h1, {15'h0, h_tr});
    cyc(1);
    h_tv = 1'b0;
    cyc(1);
  endtask
  task automatic dev_send(input logic [7:0] b);
    d_td = b;
    d_tv = 1'b1;
    for (int i = 0; i < 4000 && d_tr !== 1'b1; i++) cyc(1);
    chk("dev_tx_ready", 16'h1, {15'h0, d_tr});
    cyc(1);
    d_tv = 1'b0;
    cyc(1);
  endtask
  task automatic dev_recv(input logic [7:0] b);
    for (int i = 0; i < 4000 && d_rv !== 1'b1; i++) cyc(1);
    chk("dev_rx_data", {8'h00, b}, {8'h00, d_rd});
    chk("dev_rx_err", 16'h0, {15'h0, d_err});
    d_rr = 1'b1;
    cyc(1);
    d_rr = 1'b0;
    cyc(1);
  endtask
  task automatic host_recv(input logic [7:0] b);
    for (int i = 0; i < 4000 && h_rv !== 1'b1; i++) cyc(1);
    chk("host_rx_data", {8'h00, b}, {8'h00, h_rd});
    h_rr = 1'b1;
    cyc(1);
    h_rr = 1'b0;
    cyc(1);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_frame(input logic [7:0] b, input ubrb_par_t p, input logic two);
    logic [11:0] e, f;
    int nb;
    e = {2'b11, (p == UBRB_PAR_NONE) | (^b ^ (p == UBRB_PAR_ODD)), b, 1'b0};
    nb = 10 + int'(p != UBRB_PAR_NONE) + int'(two);
    f = 12'hFFF;
    d_par = p;
    d_two = two;
    dev_send(b);
    for (int i = 0; i < 100 && lnk.d2h_line !== 1'b0; i++) cyc(1);
    cyc(8);
    for (int k = 0; k < nb; k++) begin
      f[k] = lnk.d2h_line;
      cyc(16);
    end
    chk("dev_frame_bits", {4'h0, e}, {4'h0, f});
    host_recv(b);
  endtask
  task automatic t_break_reset();
    int n;
    n = 0;
    // timeout longer than one frame, so a character is never taken for a break
    brk_to = 16'h0028;
    h_brk = 1'b1;
    while (d_bres !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("break_reset_delay", 16'h1, {15'h0, n >= 164 && n <= 170});
    chk("break_framing_err", 16'h1, {15'h0, d_rv && d_err});
    h_brk = 1'b0;
    d_rr = 1'b1;
    cyc(60);
    d_rr = 1'b0;
    chk("rx_after_break", 16'h0, {15'h0, d_rv});
  endtask
  task automatic t_send_break();
    d_brk = 1'b1;
    cyc(200);
    chk("dev_break_line", 16'h0, {15'h0, lnk.d2h_line});
    d_brk = 1'b0;
    cyc(300);
    h_rr = 1'b1;
    cyc(2);
    h_rr = 1'b0;
    chk("dev_idle_line", 16'h1, {15'h0, lnk.d2h_line});
  endtask
  task automatic t_flow();
    int ovr0;
    d_flow = 1'b1;
    d_par = UBRB_PAR_NONE;
    d_two = 1'b0;
    for (int i = 0; i < 32; i++) host_send(8'(i + 16));
    cyc(200);
    chk("dev_rts_full", 16'h1, {15'h0, lnk.d_rts_line});
    ovr0 = n_ovr;
    host_send(8'hEE);
    cyc(200);
    chk("dev_overrun", 16'h1, {15'h0, n_ovr == ovr0 + 1});
    for (int i = 0; i < 32; i++) dev_recv(8'(i + 16));
    cyc(2);
    chk("dev_rts_free", 16'h0, {15'h0, lnk.d_rts_line});
    h_flow = 1'b1;
    d_flow = 1'b0;
    dev_send(8'h5A);
    cyc(200);
    chk("dev_tx_no_flow", 16'h1, {15'h0, d_tr});
    d_flow = 1'b1;
    cyc(1);
    chk("dev_tx_held", 16'h0, {15'h0, d_tr});
    host_recv(8'h5A);
    cyc(1);
    chk("dev_tx_resume", 16'h1, {15'h0, d_tr});
  endtask
  task automatic t_bypass();
    h_byp = 1'b1;
    cyc(1);
    h_byp = 1'b0;
    cyc(4);
    chk("sleep_links_open", 16'h0, {15'h0, d_sleep});
    h_lc = 1'b1;
    h_byp = 1'b1;
    cyc(1);
    h_byp = 1'b0;
    cyc(4);
    chk("deep_sleep", 16'h1, {15'h0, d_sleep});
    chk("bypass_oe", 16'h3, {12'h0, pin_oe});
    h_brk = 1'b1;
    pin_in = 4'h0;
    cyc(160);
    chk("pin_host_tx", 16'h0, {15'h0, pin_out[0]});
    chk("d2h_from_pin", 16'h0, {15'h0, lnk.d2h_line});
    h_brk = 1'b0;
    pin_in = 4'hF;
    cyc(300);
    chk("still_asleep", 16'h1, {15'h0, d_sleep});
    rst = 1'b1;
    cyc(2);
    chk("oe_in_reset", 16'h0, {15'h0, lnk.d2h_oe});
    rst = 1'b0;
    cyc(3);
    chk("sleep_cleared", 16'h0, {11'h0, d_sleep, pin_oe});
    chk("oe_after_reset", 16'h1, {15'h0, lnk.d2h_oe});
  endtask
  // ==========================================================
  // run control
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #(60000 * 4);
    n_fail++;
    $display("watchdog expired");
    stop_test();
  end
  initial begin
    {rst, d_flow, d_two, d_tv, d_brk, d_rr, h_drv, h_flow, h_brk, h_byp, h_lc} = 11'h400;
    {h_tv, h_rr, d_td, h_td} = '0;
    h_drv = 1'b1;
    brk_to = 16'h01A4;
    pin_in = 4'hF;
    d_par = UBRB_PAR_NONE;
    n_fail = 0;
    samples_checked = 0;
    cyc(5);
    chk("oe_held_reset", 16'h0, {14'h0, lnk.d2h_oe, lnk.d_rts_oe});
    cyc(1);
    rst = 1'b0;
    cyc(3);
    chk("oe_released", 16'h3, {14'h0, lnk.d2h_oe, lnk.d_rts_oe});
    host_send(8'hA5);
    dev_recv(8'hA5);
    t_frame(8'hC3, UBRB_PAR_NONE, 1'b0);
    t_frame(8'h3C, UBRB_PAR_ODD, 1'b0);
    t_frame(8'h07, UBRB_PAR_EVEN, 1'b1);
    t_flow();
    t_break_reset();
    t_send_break();
    t_bypass();
    stop_test();
  end
endmodule
